// ---- design/dtm_test_access.sv ----
// Test controller and per-module core multiplexers for embedded DRAM
// Operation
// - Shared data pads: direction 1 means input, 0 means device drives out.
// - Fail flag is 1 after a detected failure, 0 when no error.
// - Controller reset is active low and holds the controller in reset.
// - Activate, burn-in select and march select inputs are active high.
// - Test select 0 routes core lines from custom logic, 1 from controller.
// - Clock select 0 uses functional clock, 1 uses tester clock.
// - Bank row and bank column outputs equal the 4-bit load-bank value.
// - Wafer burn-in mode always asserts master wordline select mode too.
// - Tester clock rising edges step the controller, which runs on mclk_in; the tester clock is also routed to the core.
// - Clock enable, output enable and both selects exist once per module.
// - Controller drives regulator on, 5-bit margin step, margin disable.
// - A block has 1024 columns by 256 rows over a 64-bit internal bus.
// - Functional data width is 16, 32, 64 or 128 bits.
// - Core clock enable at 0 stops the core clock; no automatic refresh.
module dtm_test_access
  import dtm_pkg::*;
#(
  parameter int MODULES = 1,
  parameter int DATA_W = 16,
  parameter int COL_W = 4,
  parameter int BANK_W = 4,
  parameter int READ_LAT = DTM_READ_LAT
)
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic tester_clock_in,
  input wire logic test_ctrl_reset_n_in,
  input wire logic test_activate_in,
  input wire logic burn_in_select_in,
  input wire logic march_test_select_in,
  input wire logic test_pad_direction_in,
  input wire logic [dtm_pkg::DTM_TDATA_W-1:0] tester_data_in,
  input wire logic [dtm_pkg::DTM_ADDR_W-1:0] tester_address_in,
  input wire logic [dtm_pkg::DTM_CMD_W-1:0] tester_command_in,
  output logic [dtm_pkg::DTM_TDATA_W-1:0] tester_data_out,
  output logic tester_data_oe_out,
  output logic test_fail_flag_out,
  output logic regulator_on_out,
  output logic [dtm_pkg::DTM_MARGIN_W-1:0] margin_step_out,
  output logic margin_disable_out,
  output logic wafer_burnin_mode_out,
  output logic master_wordline_select_mode_out,
  output logic [BANK_W-1:0] test_bank_row_sel_out,
  output logic [BANK_W-1:0] test_bank_col_sel_out,
  input wire logic [dtm_pkg::DTM_TDATA_W-1:0] test_core_dout_in,
  input wire logic functional_clock_in,
  input wire logic [MODULES*4-1:0] func_cmd_in,
  input wire logic [MODULES*8-1:0] func_arow_in,
  input wire logic [MODULES*COL_W-1:0] func_acol_in,
  input wire logic [MODULES*BANK_W-1:0] func_brow_in,
  input wire logic [MODULES*BANK_W-1:0] func_bcol_in,
  input wire logic [MODULES*DATA_W-1:0] func_data_in,
  input wire logic [MODULES-1:0] core_clock_enable_in,
  input wire logic [MODULES-1:0] func_oen_in,
  output logic [MODULES-1:0] core_clock_out,
  output logic [MODULES*4-1:0] core_cmd_out,
  output logic [MODULES*8-1:0] core_arow_out,
  output logic [MODULES*COL_W-1:0] core_acol_out,
  output logic [MODULES*BANK_W-1:0] core_brow_out,
  output logic [MODULES*BANK_W-1:0] core_bcol_out,
  output logic [MODULES*DATA_W-1:0] core_data_out,
  output logic [MODULES-1:0] core_cke_out,
  output logic [MODULES-1:0] core_oen_n_out,
  output logic [MODULES-1:0] test_source_select_out,
  output logic [MODULES-1:0] core_clock_select_out,
  output logic [MODULES-1:0] test_clock_enable_out,
  output logic [MODULES-1:0] test_output_enable_n_out
);
  // Data width limited to 16, 32, 64 or 128 by the caller
  localparam int DATA_REP = DATA_W / DTM_TDI_W;

  logic ctl_rst;
  logic tck_reg;
  logic tc_en;
  logic cmd_take;
  logic [MODULES-1:0] mod_mask;
  logic [DTM_LOAD_BANK_W-1:0] bank_reg;
  logic [DTM_ROW_W-1:0] row_reg;
  logic [COL_W-1:0] col_reg;
  logic [DTM_TDI_W-1:0] tdi_reg;
  logic [3:0] test_cmd_reg;
  logic [DTM_TDATA_W-1:0] expect_reg;
  logic [1:0] lat_reg;
  logic fail_set;
  logic fail_clr;
  dtm_state_t state_reg;
  dtm_state_t state_next;

  // Controller held in reset by the chip reset or the tester reset
  assign ctl_rst = rst_in | ~test_ctrl_reset_n_in;

  // Tester clock rising edge as a one-cycle enable
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      tck_reg <= 1'b0;
    else
      tck_reg <= tester_clock_in;
  end

  assign tc_en = tester_clock_in & ~tck_reg;
  assign cmd_take = tc_en & test_activate_in;
  assign mod_mask = tester_data_in[MODULES-1:0];

  // Pad direction: drive out only while direction select is 0
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      tester_data_oe_out <= 1'b0;
    else
      tester_data_oe_out <= ~test_pad_direction_in;
  end

  // Address, bank and write data loaded by tester commands
  always_ff @(posedge mclk_in)
  begin
    if (ctl_rst)
    begin
      bank_reg <= '0;
      row_reg <= '0;
      col_reg <= '0;
      tdi_reg <= '0;
    end
    else if (cmd_take)
    begin
      unique case (tester_command_in)
        DTM_TC_LOAD_BANK:
          bank_reg <= tester_address_in[DTM_LOAD_BANK_W-1:0];
        DTM_TC_LOAD_ROW:
          row_reg <= tester_address_in;
        DTM_TC_LOAD_COL:
          col_reg <= tester_address_in[COL_W-1:0];
        DTM_TC_WRITE:
        begin
          tdi_reg <= tester_data_in[DTM_TDI_W-1:0];
          if (march_test_select_in)
            row_reg <= row_reg + 8'h01;
        end
        DTM_TC_READ:
        begin
          if (march_test_select_in)
            row_reg <= row_reg + 8'h01;
        end
        default:
        begin
        end
      endcase
    end
  end

  // Bank row and column both follow the loaded bank
  always_ff @(posedge mclk_in)
  begin
    if (ctl_rst)
    begin
      test_bank_row_sel_out <= '0;
      test_bank_col_sel_out <= '0;
    end
    else
    begin
      test_bank_row_sel_out <= bank_reg[BANK_W-1:0];
      test_bank_col_sel_out <= bank_reg[BANK_W-1:0];
    end
  end

  // Core command: one tester clock period per command, else no-op
  always_ff @(posedge mclk_in)
  begin
    if (ctl_rst)
      test_cmd_reg <= DTM_CORE_NOP;
    else if (tc_en)
    begin
      if (!test_activate_in)
        test_cmd_reg <= DTM_CORE_NOP;
      else if (tester_command_in == DTM_TC_WRITE)
        test_cmd_reg <= DTM_CORE_WRITE;
      else if (tester_command_in == DTM_TC_READ)
        test_cmd_reg <= DTM_CORE_READ;
      else if (tester_command_in == DTM_TC_CORE_RAW)
        test_cmd_reg <= tester_data_in[3:0];
      else
        test_cmd_reg <= DTM_CORE_NOP;
    end
  end

  // Read compare sequence, advanced by tester clock edges
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      DTM_IDLE:
        if (cmd_take && tester_command_in == DTM_TC_READ)
          state_next = DTM_WAIT;
      DTM_WAIT:
        if (tc_en && lat_reg == 2'(READ_LAT - 1))
          state_next = DTM_CHECK;
      DTM_CHECK:
        state_next = DTM_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (ctl_rst)
    begin
      state_reg <= DTM_IDLE;
      lat_reg <= '0;
      expect_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == DTM_IDLE)
      begin
        lat_reg <= '0;
        expect_reg <= tester_data_in;
      end
      else if (state_reg == DTM_WAIT && tc_en)
        lat_reg <= lat_reg + 2'h1;
    end
  end

  // Read data returned to the tester
  always_ff @(posedge mclk_in)
  begin
    if (ctl_rst)
      tester_data_out <= '0;
    else if (state_reg == DTM_CHECK)
      tester_data_out <= test_core_dout_in;
  end

  // Sticky fail flag, a new failure wins over a clear
  assign fail_set = state_reg == DTM_CHECK && test_core_dout_in != expect_reg;
  assign fail_clr = cmd_take && tester_command_in == DTM_TC_CLEAR_FAIL;

  always_ff @(posedge mclk_in)
  begin
    if (ctl_rst)
      test_fail_flag_out <= 1'b0;
    else if (fail_set)
      test_fail_flag_out <= 1'b1;
    else if (fail_clr)
      test_fail_flag_out <= 1'b0;
  end

  // Regulator and margin controls
  always_ff @(posedge mclk_in)
  begin
    if (ctl_rst)
    begin
      regulator_on_out <= DTM_REG_ON_RST;
      margin_step_out <= DTM_MARGIN_RST;
      margin_disable_out <= DTM_MARG_OFF_RST;
    end
    else if (cmd_take && tester_command_in == DTM_TC_SET_MARGIN)
    begin
      regulator_on_out <= tester_address_in[DTM_REG_ON_BIT];
      margin_step_out <= tester_address_in[DTM_MARGIN_W-1:0];
      margin_disable_out <= tester_address_in[DTM_MARG_OFF_BIT];
    end
  end

  // Burn-in always brings master wordline select with it
  always_ff @(posedge mclk_in)
  begin
    if (ctl_rst)
    begin
      wafer_burnin_mode_out <= 1'b0;
      master_wordline_select_mode_out <= 1'b0;
    end
    else
    begin
      wafer_burnin_mode_out <= test_activate_in & burn_in_select_in;
      master_wordline_select_mode_out <=
        test_activate_in & burn_in_select_in;
    end
  end

  // Per-module route, clock, enable settings
  always_ff @(posedge mclk_in)
  begin
    if (ctl_rst || !test_activate_in)
    begin
      test_source_select_out <= '0;
      core_clock_select_out <= '0;
    end
    else if (cmd_take && tester_command_in == DTM_TC_SET_ROUTE)
    begin
      for (int i = 0; i < MODULES; i++)
      begin
        if (mod_mask[i])
        begin
          test_source_select_out[i] <=
            tester_address_in[DTM_ROUTE_SRC_BIT];
          core_clock_select_out[i] <=
            tester_address_in[DTM_ROUTE_CLK_BIT];
        end
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (ctl_rst)
    begin
      test_clock_enable_out <= {MODULES{DTM_TCKE_RST}};
      test_output_enable_n_out <= {MODULES{DTM_TOEN_RST}};
    end
    else if (cmd_take && tester_command_in == DTM_TC_SET_ENABLE)
    begin
      for (int i = 0; i < MODULES; i++)
      begin
        if (mod_mask[i])
        begin
          test_clock_enable_out[i] <=
            tester_address_in[DTM_EN_CKE_BIT];
          test_output_enable_n_out[i] <=
            tester_address_in[DTM_EN_OEN_BIT];
        end
      end
    end
  end

  // One multiplexer per attached memory module
  for (genvar m = 0; m < MODULES; m++)
  begin : g_mod
    dtm_core_mux #(
      .DATA_W(DATA_W),
      .COL_W(COL_W),
      .BANK_W(BANK_W)
    ) u_mux (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .test_sel_in(test_source_select_out[m]),
      .clk_sel_in(core_clock_select_out[m]),
      .functional_clock_in(functional_clock_in),
      .tester_clock_in(tester_clock_in),
      .func_cmd_in(func_cmd_in[m*4 +: 4]),
      .func_arow_in(func_arow_in[m*8 +: 8]),
      .func_acol_in(func_acol_in[m*COL_W +: COL_W]),
      .func_brow_in(func_brow_in[m*BANK_W +: BANK_W]),
      .func_bcol_in(func_bcol_in[m*BANK_W +: BANK_W]),
      .func_data_in(func_data_in[m*DATA_W +: DATA_W]),
      .func_cke_in(core_clock_enable_in[m]),
      .func_oen_in(func_oen_in[m]),
      .test_cmd_in(test_cmd_reg),
      .test_arow_in(row_reg),
      .test_acol_in(col_reg),
      .test_brow_in(test_bank_row_sel_out),
      .test_bcol_in(test_bank_col_sel_out),
      .test_data_in({DATA_REP{tdi_reg}}),
      .test_cke_in(test_clock_enable_out[m]),
      .test_oen_in(test_output_enable_n_out[m]),
      .core_clock_out(core_clock_out[m]),
      .core_cmd_out(core_cmd_out[m*4 +: 4]),
      .core_arow_out(core_arow_out[m*8 +: 8]),
      .core_acol_out(core_acol_out[m*COL_W +: COL_W]),
      .core_brow_out(core_brow_out[m*BANK_W +: BANK_W]),
      .core_bcol_out(core_bcol_out[m*BANK_W +: BANK_W]),
      .core_data_out(core_data_out[m*DATA_W +: DATA_W]),
      .core_cke_out(core_cke_out[m]),
      .core_oen_n_out(core_oen_n_out[m])
    );
  end
endmodule : dtm_test_access

// ---- design/dtm_pkg.sv ----
// Shared constants and types for the DRAM test access block
package dtm_pkg;
  localparam int DTM_TDATA_W = 16;
  localparam int DTM_ADDR_W = 8;
  localparam int DTM_CMD_W = 4;
  localparam int DTM_LOAD_BANK_W = 4;
  localparam int DTM_MARGIN_W = 5;
  localparam int DTM_TDI_W = 4;
  localparam int DTM_ROW_W = 8;
  localparam int DTM_MAX_MODULES = 16;

  // Tester command codes
  localparam logic [3:0] DTM_TC_NOP = 4'h0;
  localparam logic [3:0] DTM_TC_LOAD_BANK = 4'h1;
  localparam logic [3:0] DTM_TC_LOAD_ROW = 4'h2;
  localparam logic [3:0] DTM_TC_LOAD_COL = 4'h3;
  localparam logic [3:0] DTM_TC_WRITE = 4'h4;
  localparam logic [3:0] DTM_TC_READ = 4'h5;
  localparam logic [3:0] DTM_TC_CORE_RAW = 4'h6;
  localparam logic [3:0] DTM_TC_SET_MARGIN = 4'h7;
  localparam logic [3:0] DTM_TC_SET_ROUTE = 4'h8;
  localparam logic [3:0] DTM_TC_SET_ENABLE = 4'h9;
  localparam logic [3:0] DTM_TC_CLEAR_FAIL = 4'hA;

  // Core command codes issued by the controller
  localparam logic [3:0] DTM_CORE_NOP = 4'h0;
  localparam logic [3:0] DTM_CORE_WRITE = 4'h4;
  localparam logic [3:0] DTM_CORE_READ = 4'h5;

  // Field positions inside tester_address for settings commands
  localparam int DTM_ROUTE_SRC_BIT = 0;
  localparam int DTM_ROUTE_CLK_BIT = 1;
  localparam int DTM_EN_CKE_BIT = 0;
  localparam int DTM_EN_OEN_BIT = 1;
  localparam int DTM_MARG_OFF_BIT = 5;
  localparam int DTM_REG_ON_BIT = 6;

  // Reset values
  localparam logic DTM_REG_ON_RST = 1'b1;
  localparam logic [4:0] DTM_MARGIN_RST = 5'h00;
  localparam logic DTM_MARG_OFF_RST = 1'b0;
  localparam logic DTM_TCKE_RST = 1'b1;
  localparam logic DTM_TOEN_RST = 1'b0;

  // Tester clock edges from read command to data compare
  localparam int DTM_READ_LAT = 2;

  typedef enum logic [1:0] {DTM_IDLE, DTM_WAIT, DTM_CHECK} dtm_state_t;
endpackage : dtm_pkg

// ---- design/dtm_core_mux.sv ----
// Per-module source and clock selection for one DRAM core
module dtm_core_mux
  import dtm_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int COL_W = 4,
  parameter int BANK_W = 4
)
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic test_sel_in,
  input wire logic clk_sel_in,
  input wire logic functional_clock_in,
  input wire logic tester_clock_in,
  input wire logic [3:0] func_cmd_in,
  input wire logic [7:0] func_arow_in,
  input wire logic [COL_W-1:0] func_acol_in,
  input wire logic [BANK_W-1:0] func_brow_in,
  input wire logic [BANK_W-1:0] func_bcol_in,
  input wire logic [DATA_W-1:0] func_data_in,
  input wire logic func_cke_in,
  input wire logic func_oen_in,
  input wire logic [3:0] test_cmd_in,
  input wire logic [7:0] test_arow_in,
  input wire logic [COL_W-1:0] test_acol_in,
  input wire logic [BANK_W-1:0] test_brow_in,
  input wire logic [BANK_W-1:0] test_bcol_in,
  input wire logic [DATA_W-1:0] test_data_in,
  input wire logic test_cke_in,
  input wire logic test_oen_in,
  output logic core_clock_out,
  output logic [3:0] core_cmd_out,
  output logic [7:0] core_arow_out,
  output logic [COL_W-1:0] core_acol_out,
  output logic [BANK_W-1:0] core_brow_out,
  output logic [BANK_W-1:0] core_bcol_out,
  output logic [DATA_W-1:0] core_data_out,
  output logic core_cke_out,
  output logic core_oen_n_out
);
  // Clock source select
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      core_clock_out <= 1'b0;
    else
      core_clock_out <= clk_sel_in ? tester_clock_in : functional_clock_in;
  end

  // Command, address, data and control source select
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      core_cmd_out <= DTM_CORE_NOP;
      core_arow_out <= '0;
      core_acol_out <= '0;
      core_brow_out <= '0;
      core_bcol_out <= '0;
      core_data_out <= '0;
      core_cke_out <= 1'b0;
      core_oen_n_out <= 1'b1;
    end
    else if (test_sel_in)
    begin
      core_cmd_out <= test_cmd_in;
      core_arow_out <= test_arow_in;
      core_acol_out <= test_acol_in;
      core_brow_out <= test_brow_in;
      core_bcol_out <= test_bcol_in;
      core_data_out <= test_data_in;
      core_cke_out <= test_cke_in;
      core_oen_n_out <= test_oen_in;
    end
    else
    begin
      core_cmd_out <= func_cmd_in;
      core_arow_out <= func_arow_in;
      core_acol_out <= func_acol_in;
      core_brow_out <= func_brow_in;
      core_bcol_out <= func_bcol_in;
      core_data_out <= func_data_in;
      core_cke_out <= func_cke_in;
      core_oen_n_out <= func_oen_in;
    end
  end
endmodule : dtm_core_mux

// ---- verification/dtm_access_properties.sv ----
// Concurrent checks on the DRAM test access ports
module dtm_access_check
  import dtm_pkg::*;
#(
  parameter int MODULES = 1,
  parameter int BANK_W = 4
)
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic tester_clock_in,
  input wire logic test_ctrl_reset_n_in,
  input wire logic test_activate_in,
  input wire logic burn_in_select_in,
  input wire logic test_pad_direction_in,
  input wire logic [15:0] tester_data_in,
  input wire logic [7:0] tester_address_in,
  input wire logic [3:0] tester_command_in,
  input wire logic tester_data_oe_out,
  input wire logic test_fail_flag_out,
  input wire logic regulator_on_out,
  input wire logic [4:0] margin_step_out,
  input wire logic margin_disable_out,
  input wire logic wafer_burnin_mode_out,
  input wire logic master_wordline_select_mode_out,
  input wire logic [BANK_W-1:0] test_bank_row_sel_out,
  input wire logic [BANK_W-1:0] test_bank_col_sel_out,
  input wire logic [MODULES*4-1:0] func_cmd_in,
  input wire logic [MODULES*4-1:0] core_cmd_out,
  input wire logic [MODULES-1:0] test_source_select_out,
  input wire logic [MODULES-1:0] core_clock_select_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [MODULES-1:0] mask;
  logic [MODULES-1:0] src_want;
  logic [MODULES-1:0] clk_want;
  assign mask = tester_data_in[MODULES-1:0];
  assign src_want = (test_source_select_out & ~mask)
    | (mask & {MODULES{tester_address_in[DTM_ROUTE_SRC_BIT]}});
  assign clk_want = (core_clock_select_out & ~mask)
    | (mask & {MODULES{tester_address_in[DTM_ROUTE_CLK_BIT]}});
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Rising tester clock seen by an active controller
  sequence s_taken;
    !tester_clock_in ##1 (tester_clock_in && test_activate_in
      && test_ctrl_reset_n_in);
  endsequence
  sequence s_cmd(logic [3:0] code);
    s_taken ##0 (tester_command_in == code);
  endsequence
  a_margin_load: assert property (s_cmd(DTM_TC_SET_MARGIN) |=>
    margin_step_out == $past(tester_address_in[4:0])
    && margin_disable_out == $past(tester_address_in[DTM_MARG_OFF_BIT])
    && regulator_on_out == $past(tester_address_in[DTM_REG_ON_BIT]))
    else $error("margin settings did not follow the command");
  a_bank_load: assert property (s_cmd(DTM_TC_LOAD_BANK) |=> ##1
    test_bank_row_sel_out == $past(tester_address_in[BANK_W-1:0], 2)
    && test_bank_col_sel_out == test_bank_row_sel_out)
    else $error("bank selects did not load");
  a_route_load: assert property (s_cmd(DTM_TC_SET_ROUTE) |=>
    test_source_select_out == $past(src_want)
    && core_clock_select_out == $past(clk_want))
    else $error("route selects did not follow the command");
  a_custom_source: assert property (!$past(rst_in)
    && !$past(test_source_select_out[0])
    |-> core_cmd_out[3:0] == $past(func_cmd_in[3:0]))
    else $error("custom command not routed to the core");
  a_pad_drive: assert property (!$past(rst_in)
    |-> tester_data_oe_out == !$past(test_pad_direction_in))
    else $error("pad drive does not follow direction");
  a_idle_selects: assert property (!test_activate_in ##1
    !test_activate_in |-> test_source_select_out == '0
    && core_clock_select_out == '0)
    else $error("selects set while controller inactive");
  a_ctrl_reset: assert property (!test_ctrl_reset_n_in |=>
    !test_fail_flag_out && regulator_on_out)
    else $error("controller reset not applied");
  a_burnin_mwl: assert property (wafer_burnin_mode_out ==
    master_wordline_select_mode_out)
    else $error("burn-in without wordline select mode");
  a_burnin_on: assert property (test_activate_in &&
    burn_in_select_in && test_ctrl_reset_n_in |=> wafer_burnin_mode_out)
    else $error("burn-in select ignored");
endmodule : dtm_access_check

bind dtm_test_access dtm_access_check #(.MODULES(MODULES), .BANK_W(BANK_W))
  dtm_access_check_inst (.mclk_in, .rst_in, .tester_clock_in,
  .test_ctrl_reset_n_in, .test_activate_in, .burn_in_select_in,
  .test_pad_direction_in, .tester_data_in, .tester_address_in,
  .tester_command_in, .tester_data_oe_out, .test_fail_flag_out,
  .regulator_on_out, .margin_step_out, .margin_disable_out,
  .wafer_burnin_mode_out, .master_wordline_select_mode_out,
  .test_bank_row_sel_out, .test_bank_col_sel_out, .func_cmd_in,
  .core_cmd_out, .test_source_select_out, .core_clock_select_out);

// ---- verification/dtm_core_model.sv ----
// Behavioural DRAM core answering test writes and reads
module dtm_core_model
  import dtm_pkg::*;
(
  input wire logic core_clock_in,
  input wire logic [3:0] cmd_in,
  input wire logic [7:0] arow_in,
  input wire logic [15:0] data_in,
  input wire logic [15:0] corrupt_in,
  output logic [15:0] dout_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [256];
  initial dout_out = 16'h0000;
  // Command and address taken at the core clock edge
  always @(posedge core_clock_in)
  begin
    if (cmd_in == DTM_CORE_WRITE)
      mem[arow_in] <= data_in;
    if (cmd_in == DTM_CORE_READ)
      dout_out <= mem[arow_in] ^ corrupt_in;
  end
endmodule : dtm_core_model

// ---- verification/tb_dram_test_access_mux.sv ----
// Directed testbench for the DRAM test access block
module tb_dram_test_access_mux;
  timeunit 1ns;
  timeprecision 100ps;
  import dtm_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic tcrn = 1'b1;
  logic act = 1'b0;
  logic burn = 1'b0;
  logic march = 1'b0;
  logic pad = 1'b1;
  logic tck = 1'b0;
  logic [15:0] tdi = 16'h0000;
  logic [7:0] taddr = 8'h00;
  logic [3:0] tcmd = 4'h0;
  logic [15:0] fv = 16'h003C;
  logic [15:0] bad = 16'h0000;
  logic [15:0] tdo;
  logic [15:0] cdout;
  logic [31:0] cdata;
  logic [15:0] carow;
  logic [7:0] ccmd, cacol;
  logic [4:0] mstep;
  logic [3:0] brs, bcs;
  logic [1:0] cclk, tsel, csel, tcke, toen, ccke, coen;
  logic oe, fail, regon, moff, wbi, mwls;
  logic [7:0] mg [2] = '{8'h5A, 8'h3F};
  int err_total = 0;
  int n_checks = 0;

  initial forever #4 mclk_in = ~mclk_in;

  dtm_test_access #(.MODULES(2)) dtm_test_access_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .tester_clock_in(tck),
    .test_ctrl_reset_n_in(tcrn), .test_activate_in(act),
    .burn_in_select_in(burn), .march_test_select_in(march),
    .test_pad_direction_in(pad), .tester_data_in(tdi),
    .tester_address_in(taddr), .tester_command_in(tcmd),
    .tester_data_out(tdo), .tester_data_oe_out(oe),
    .test_fail_flag_out(fail), .regulator_on_out(regon),
    .margin_step_out(mstep), .margin_disable_out(moff),
    .wafer_burnin_mode_out(wbi), .master_wordline_select_mode_out(mwls),
    .test_bank_row_sel_out(brs), .test_bank_col_sel_out(bcs),
    .test_core_dout_in(cdout), .functional_clock_in(fv[15]),
    .func_cmd_in(fv[7:0]), .func_arow_in(fv), .func_acol_in(fv[7:0]),
    .func_brow_in(fv[7:0]), .func_bcol_in(fv[15:8]),
    .func_data_in({fv, fv}), .core_clock_enable_in(fv[1:0]),
    .func_oen_in(fv[3:2]), .core_clock_out(cclk), .core_cmd_out(ccmd),
    .core_arow_out(carow), .core_acol_out(cacol), .core_brow_out(),
    .core_bcol_out(), .core_data_out(cdata), .core_cke_out(ccke),
    .core_oen_n_out(coen), .test_source_select_out(tsel),
    .core_clock_select_out(csel), .test_clock_enable_out(tcke),
    .test_output_enable_n_out(toen));

  dtm_core_model dtm_core_model_inst (.core_clock_in(cclk[0]),
    .cmd_in(ccmd[3:0]), .arow_in(carow[7:0]), .data_in(cdata[15:0]),
    .corrupt_in(bad), .dout_out(cdout));

  task automatic chk(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : step

  // One tester clock period carrying one command
  task automatic tc(input logic [3:0] c, input logic [7:0] a,
    input logic [15:0] d);
    step(1);
    tcmd = c;
    taddr = a;
    tdi = d;
    tck = 1'b1;
    step(4);
    tck = 1'b0;
    step(4);
  endtask : tc

  task automatic rd(input logic [15:0] e);
    tc(DTM_TC_READ, 8'h00, e);
    repeat (2) tc(DTM_TC_NOP, 8'h00, 16'h0000);
  endtask : rd

  initial
  begin
    #100us;
    err_total++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    step(2);
    chk("reg_on", regon, 1'b1);
    chk("test_cke", tcke, 2'b11);
    chk("fail", fail, 1'b0);
    chk("pad_oe", oe, 1'b0);
    tc(DTM_TC_SET_ROUTE, 8'h03, 16'h0003);
    chk("idle_src", tsel, 2'b00);
    act = 1'b1;
    tc(DTM_TC_SET_ROUTE, 8'h03, 16'h0001);
    chk("src_sel", tsel, 2'b01);
    chk("clk_sel", csel, 2'b01);
    fv[15] = 1'b1;
    step(3);
    chk("core_clk", cclk, 2'b10);
    tcmd = DTM_TC_NOP;
    tck = 1'b1;
    fv[15] = 1'b0;
    step(3);
    chk("core_clk", cclk, 2'b01);
    tck = 1'b0;
    step(3);
    tc(DTM_TC_SET_ENABLE, 8'h02, 16'h0002);
    chk("test_cke", tcke, 2'b01);
    chk("test_oen", toen, 2'b10);
    chk("core_cke", ccke, 2'b01);
    chk("core_oen", coen, 2'b10);
    tc(DTM_TC_LOAD_BANK, 8'hF5, 16'h0000);
    chk("bank_row", brs, 4'h5);
    chk("bank_col", bcs, 4'h5);
    foreach (mg[i])
    begin
      tc(DTM_TC_SET_MARGIN, mg[i], 16'h0000);
      chk("margin", mstep, mg[i][4:0]);
      chk("margin_off", moff, mg[i][5]);
      chk("reg_on", regon, mg[i][6]);
    end
    burn = 1'b1;
    step(2);
    chk("burn_in", {wbi, mwls}, 2'b11);
    burn = 1'b0;
    step(2);
    chk("burn_in", {wbi, mwls}, 2'b00);
    pad = 1'b0;
    step(2);
    chk("pad_oe", oe, 1'b1);
    pad = 1'b1;
    step(2);
    chk("pad_oe", oe, 1'b0);
    tc(DTM_TC_CORE_RAW, 8'h00, 16'h0006);
    chk("core_cmd", ccmd, 8'h36);
    tc(DTM_TC_LOAD_COL, 8'h09, 16'h0000);
    chk("core_col", cacol[3:0], 4'h9);
    march = 1'b1;
    tc(DTM_TC_LOAD_ROW, 8'h07, 16'h0000);
    tc(DTM_TC_WRITE, 8'h00, 16'h000A);
    chk("march_row", carow[7:0], 8'h08);
    march = 1'b0;
    tc(DTM_TC_LOAD_ROW, 8'h07, 16'h0000);
    tc(DTM_TC_WRITE, 8'h00, 16'h000A);
    chk("core_data", cdata[15:0], 16'hAAAA);
    tc(DTM_TC_LOAD_ROW, 8'h08, 16'h0000);
    tc(DTM_TC_WRITE, 8'h00, 16'h0005);
    rd(16'h5555);
    chk("fail", fail, 1'b0);
    chk("read", tdo, 16'h5555);
    tc(DTM_TC_LOAD_ROW, 8'h07, 16'h0000);
    bad = 16'h0001;
    rd(16'hAAAA);
    chk("fail", fail, 1'b1);
    chk("read", tdo, 16'hAAAB);
    bad = 16'h0000;
    tc(DTM_TC_CLEAR_FAIL, 8'h00, 16'h0000);
    chk("fail", fail, 1'b0);
    rd(16'h1234);
    chk("fail", fail, 1'b1);
    tcrn = 1'b0;
    step(2);
    tcrn = 1'b1;
    step(2);
    chk("fail", fail, 1'b0);
    chk("reg_on", regon, 1'b1);
    conclude();
  end
endmodule : tb_dram_test_access_mux
